/* core/ess_defs.vh */
// Purpose: constants for the emulator switch settings block
// Assumes: included by bare name
// Notes: definitions only
`ifndef ESS_DEFS_VH
`define ESS_DEFS_VH
// Switch bit positions
`define ESS_SW_BKX 0
`define ESS_SW_CLK 1
`define ESS_SW_CPY 2
`define ESS_SW_FSX 3
`define ESS_SW_RDY 4
`define ESS_SW_DMA 5
`define ESS_SW_TE0 6
`define ESS_SW_TE1 7
`define ESS_SW_TE2 8
`define ESS_SW_STI 9
`define ESS_SW_RCS 10
`define ESS_SW_W 11
// Power-up switch word: clock select and forced-interrupt timing on
`define ESS_SW_RST 11'h00a
// Command codes
`define ESS_CMD_ON 3'h1
`define ESS_CMD_OFF 3'h2
`define ESS_CMD_SET 3'h3
`define ESS_CMD_LOAD 3'h4
`define ESS_CMD_SAVE 3'h5
// Parameter numbers
`define ESS_P_USER 8'h01
`define ESS_P_RSTCH 8'h02
`define ESS_P_XON 8'h03
`define ESS_P_T_BAUD 8'h0a
`define ESS_P_T_STOP 8'h0b
`define ESS_P_T_PAR 8'h0c
`define ESS_P_LINES 8'h0d
`define ESS_P_RSTCH2 8'h0e
`define ESS_P_T_ESC 8'h0f
`define ESS_P_C_BAUD 8'h14
`define ESS_P_C_STOP 8'h15
`define ESS_P_C_PAR 8'h16
`define ESS_P_C_ESC 8'h17
// Reset values of settings
`define ESS_BAUD_RST 4'he
`define ESS_STOP_RST 2'h1
`define ESS_PAR_RST 2'h0
`define ESS_RSTCH_RST 7'h18
`define ESS_XON_RST 7'h11
`define ESS_XOFF_RST 7'h13
`define ESS_LINES_RST 8'h18
`define ESS_ESC_RST 14'h0000
// Settings image word count and validity mark
`define ESS_IMG_WORDS 8
`define ESS_IMG_MARK 16'h5a3c
// Save time limit in ms, and cycles per ms at 100 MHz
`define ESS_SAVE_MS 120000
`define ESS_CLK_KHZ 100000
`endif

/* core/ess_mem.v */
// Purpose: nonvolatile settings image store
// Assumes: single port, registered read data
// Notes: one word per section
`timescale 1ns/1ns
`default_nettype none
module ess_mem #(
   parameter DW = 16,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock
   input wire clk_i,
   // Access
   input wire we_i,
   input wire [AW-1:0] addr_i,
   input wire [DW-1:0] wdata_i,
   output reg [DW-1:0] rdata_o
);
   reg [DW-1:0] mem [0:DEPTH-1];
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
   end
endmodule // ess_mem
`default_nettype wire

/* core/ess_pause_ctl.v */
// Purpose: pause-state gating of target peripherals and chip-select reads
// Assumes: run_i is a level, high in any run mode
// Notes: outputs registered
`timescale 1ns/1ns
`default_nettype none
`include "ess_defs.vh"
module ess_pause_ctl #(
   parameter NCS = 5
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Mode and switches
   input wire run_i,
   input wire [`ESS_SW_W-1:0] sw_i,
   input wire [NCS-1:0] cs_wr_i,
   // Peripheral controls
   output reg dma_en_o,
   output reg [2:0] timer_en_o,
   output reg [NCS-1:0] cs_rd_o,
   output reg irq_step_en_o
);
   reg run_d_ff;
   reg [NCS-1:0] cs_arm_ff;
   wire pause_entry = run_d_ff & ~run_i;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_d_ff <= 1'b0;
         cs_arm_ff <= {NCS{1'b0}};
         dma_en_o <= 1'b0;
         timer_en_o <= 3'h0;
         cs_rd_o <= {NCS{1'b0}};
         irq_step_en_o <= 1'b0;
      end else begin
         run_d_ff <= run_i;
         dma_en_o <= run_i | sw_i[`ESS_SW_DMA];
         timer_en_o <= {3{run_i}} | sw_i[`ESS_SW_TE2:`ESS_SW_TE0];
         irq_step_en_o <= sw_i[`ESS_SW_STI];
         if (!run_i) begin
            cs_arm_ff <= cs_arm_ff | cs_wr_i;
         end
         // group readback on entry; index 0 upper excluded
         if (pause_entry) begin
            cs_rd_o <= cs_arm_ff |
               ({NCS{sw_i[`ESS_SW_RCS]}} & {{(NCS-1){1'b1}}, 1'b0});
         end else begin
            cs_rd_o <= {NCS{1'b0}};
         end
      end
   end
endmodule // ess_pause_ctl
`default_nettype wire

/* core/ess_top.v */
// Purpose: emulator switch and serial settings bank
// Assumes: commands arrive decoded, one-cycle strobe
// Notes: chip-select index 0 is the upper memory select register
`timescale 1ns/1ns
`default_nettype none
`include "ess_defs.vh"
module ess_top #(
   parameter NCS = 5,
   // Two minutes of cycles does not fit in 32 bits, so reckon in 64
   parameter [63:0] SAVE_CYC = 64'h0 + `ESS_SAVE_MS * `ESS_CLK_KHZ,
   parameter WR_CYC = 100
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Operator command
   input wire cmd_vld_i,
   input wire [2:0] cmd_i,
   input wire [15:0] cmd_arg_i,
   input wire [7:0] cmd_par_i,
   input wire [7:0] cmd_val_i,
   input wire [7:0] cmd_val2_i,
   output reg cmd_done_o,
   output reg cmd_err_o,
   output reg busy_o,
   // Serial ports: received chars, output routing
   input wire term_rx_vld_i,
   input wire [6:0] term_rx_i,
   input wire host_rx_vld_i,
   input wire [6:0] host_rx_i,
   input wire host_ctl_i,
   output reg self_reset_o,
   output reg term_tx_en_o,
   output reg host_tx_en_o,
   // Emulation
   input wire run_i,
   input wire [NCS-1:0] cs_wr_i,
   input wire exec_match_i,
   input wire fetch_match_i,
   input wire fsi_exec_i,
   input wire fsi_fetch_i,
   input wire overlay_i,
   input wire tgt_ready_i,
   output reg break_o,
   output reg fsi_o,
   output reg ready_o,
   output reg clk_sel_int_o,
   output reg [`ESS_SW_W-1:0] switches_o,
   output wire dma_en_o,
   output wire [2:0] timer_en_o,
   output wire [NCS-1:0] cs_rd_o,
   output wire irq_step_en_o,
   // Effective serial settings
   output reg [3:0] term_baud_o,
   output reg [1:0] term_stop_o,
   output reg [1:0] term_par_o,
   output reg [3:0] host_baud_o,
   output reg [1:0] host_stop_o,
   output reg [1:0] host_par_o,
   output reg [6:0] reset_char_o,
   output reg [6:0] xon_o,
   output reg [6:0] xoff_o,
   output reg [13:0] term_esc_o,
   output reg [13:0] host_esc_o,
   output reg [7:0] lines_o,
   output reg user_o
);
   // ******************************************
   // Pending (displayed) settings
   // ******************************************
   reg [3:0] p_tbaud_ff;
   reg [1:0] p_tstop_ff;
   reg [1:0] p_tpar_ff;
   reg [1:0] p_hstop_ff;
   reg [1:0] p_hpar_ff;
   reg [31:0] cnt_ff;
   reg [3:0] idx_ff;
   reg [2:0] st_ff;
   reg ld_one_ff;
   reg [2:0] sect_ff;
   reg mem_we;
   reg [2:0] mem_addr;
   reg [15:0] mem_wdata;
   wire [15:0] mem_rdata;
   localparam ST_IDLE = 3'h0;
   localparam ST_SAVE = 3'h1;
   localparam ST_SWAIT = 3'h2;
   localparam ST_CHK = 3'h3;
   localparam ST_CHK2 = 3'h4;
   localparam ST_LOAD = 3'h5;
   localparam ST_LOAD2 = 3'h6;

   // Validity of value for a parameter number
   function ok_val;
      input [7:0] par;
      input [7:0] v;
      begin
         case (par)
            `ESS_P_USER: ok_val = (v <= 8'h01);
            `ESS_P_T_BAUD, `ESS_P_C_BAUD: ok_val = (v <= 8'h0f);
            `ESS_P_T_STOP, `ESS_P_C_STOP: ok_val = (v == 8'h01) ||
               (v == 8'h02);
            `ESS_P_T_PAR, `ESS_P_C_PAR: ok_val = (v <= 8'h02);
            `ESS_P_LINES: ok_val = (v >= 8'h05);
            `ESS_P_RSTCH, `ESS_P_RSTCH2, `ESS_P_XON, `ESS_P_T_ESC,
            `ESS_P_C_ESC: ok_val = 1'b1;
            default: ok_val = 1'b0;
         endcase
      end
   endfunction

   // Image word for a section (displayed values)
   function [15:0] img_word;
      input [2:0] s;
      begin
         case (s)
            3'h0: img_word = `ESS_IMG_MARK;
            3'h1: img_word = {5'h00, switches_o};
            3'h2: img_word = {4'h0, p_tbaud_ff, p_tstop_ff, p_tpar_ff,
               p_hstop_ff, p_hpar_ff};
            3'h3: img_word = {3'h0, host_baud_o, user_o, lines_o};
            3'h4: img_word = {2'h0, xon_o, xoff_o};
            3'h5: img_word = {2'h0, term_esc_o};
            3'h6: img_word = {2'h0, host_esc_o};
            default: img_word = {9'h000, reset_char_o};
         endcase
      end
   endfunction

   ess_mem #(.DW(16), .DEPTH(`ESS_IMG_WORDS), .AW(3)) u_mem (
      .clk_i(clk_i),
      .we_i(mem_we),
      .addr_i(mem_addr),
      .wdata_i(mem_wdata),
      .rdata_o(mem_rdata)
   );

   ess_pause_ctl #(.NCS(NCS)) u_pause (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(run_i),
      .sw_i(switches_o),
      .cs_wr_i(cs_wr_i),
      .dma_en_o(dma_en_o),
      .timer_en_o(timer_en_o),
      .cs_rd_o(cs_rd_o),
      .irq_step_en_o(irq_step_en_o)
   );

   // ******************************************
   // Reset character watch
   // ******************************************
   // any port, any mode
   wire rst_hit = (term_rx_vld_i && term_rx_i == reset_char_o) ||
      (host_rx_vld_i && host_rx_i == reset_char_o);

   wire cmd_go = cmd_vld_i && st_ff == ST_IDLE;

   always @* begin
      mem_we = 1'b0;
      mem_addr = idx_ff[2:0];
      mem_wdata = img_word(idx_ff[2:0]);
      if (st_ff == ST_SAVE) begin
         mem_we = 1'b1;
      end
   end

   // ******************************************
   // Settings and command sequencer
   // ******************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         switches_o <= `ESS_SW_RST;
         p_tbaud_ff <= `ESS_BAUD_RST;
         p_tstop_ff <= `ESS_STOP_RST;
         p_tpar_ff <= `ESS_PAR_RST;
         p_hstop_ff <= `ESS_STOP_RST;
         p_hpar_ff <= `ESS_PAR_RST;
         term_baud_o <= `ESS_BAUD_RST;
         term_stop_o <= `ESS_STOP_RST;
         term_par_o <= `ESS_PAR_RST;
         host_baud_o <= `ESS_BAUD_RST;
         host_stop_o <= `ESS_STOP_RST;
         host_par_o <= `ESS_PAR_RST;
         reset_char_o <= `ESS_RSTCH_RST;
         xon_o <= `ESS_XON_RST;
         xoff_o <= `ESS_XOFF_RST;
         term_esc_o <= `ESS_ESC_RST;
         host_esc_o <= `ESS_ESC_RST;
         lines_o <= `ESS_LINES_RST;
         user_o <= 1'b0;
         cmd_done_o <= 1'b0;
         cmd_err_o <= 1'b0;
         busy_o <= 1'b0;
         self_reset_o <= 1'b0;
         cnt_ff <= 32'h0;
         idx_ff <= 4'h0;
         st_ff <= ST_IDLE;
         ld_one_ff <= 1'b0;
         sect_ff <= 3'h0;
      end else begin
         cmd_done_o <= 1'b0;
         cmd_err_o <= 1'b0;
         self_reset_o <= rst_hit;
         // pending line settings apply on reset character
         if (rst_hit) begin
            term_baud_o <= p_tbaud_ff;
            term_stop_o <= p_tstop_ff;
            term_par_o <= p_tpar_ff;
            host_stop_o <= p_hstop_ff;
            host_par_o <= p_hpar_ff;
         end
         case (st_ff)
            ST_IDLE: begin
               busy_o <= 1'b0;
               if (cmd_go) begin
                  case (cmd_i)
                     // masked on, off, off -1 clears all
                     `ESS_CMD_ON: begin
                        switches_o <= switches_o |
                           cmd_arg_i[`ESS_SW_W-1:0];
                        cmd_done_o <= 1'b1;
                     end
                     `ESS_CMD_OFF: begin
                        if (cmd_arg_i == 16'hffff) begin
                           switches_o <= {`ESS_SW_W{1'b0}};
                        end else begin
                           switches_o <= switches_o &
                              ~cmd_arg_i[`ESS_SW_W-1:0];
                        end
                        cmd_done_o <= 1'b1;
                     end
                     `ESS_CMD_SET: begin
                        if (!ok_val(cmd_par_i, cmd_val_i)) begin
                           cmd_err_o <= 1'b1;
                        end else begin
                           cmd_done_o <= 1'b1;
                           case (cmd_par_i)
                              `ESS_P_USER: user_o <= cmd_val_i[0];
                              `ESS_P_RSTCH, `ESS_P_RSTCH2:
                                 reset_char_o <= cmd_val_i[6:0];
                              `ESS_P_XON: begin
                                 xon_o <= cmd_val_i[6:0];
                                 xoff_o <= cmd_val2_i[6:0];
                              end
                              `ESS_P_T_BAUD: p_tbaud_ff <= cmd_val_i[3:0];
                              `ESS_P_C_BAUD: host_baud_o <= cmd_val_i[3:0];
                              `ESS_P_T_STOP: p_tstop_ff <= cmd_val_i[1:0];
                              `ESS_P_C_STOP: p_hstop_ff <= cmd_val_i[1:0];
                              `ESS_P_T_PAR: p_tpar_ff <= cmd_val_i[1:0];
                              `ESS_P_C_PAR: p_hpar_ff <= cmd_val_i[1:0];
                              `ESS_P_LINES: lines_o <= cmd_val_i;
                              `ESS_P_T_ESC: term_esc_o <=
                                 {cmd_val_i[6:0], cmd_val2_i[6:0]};
                              default: host_esc_o <=
                                 {cmd_val_i[6:0], cmd_val2_i[6:0]};
                           endcase
                        end
                     end
                     `ESS_CMD_SAVE: begin
                        busy_o <= 1'b1;
                        ld_one_ff <= cmd_arg_i != 16'h0000;
                        sect_ff <= cmd_arg_i[2:0];
                        idx_ff <= (cmd_arg_i != 16'h0000) ?
                           {1'b0, cmd_arg_i[2:0]} : 4'h0;
                        cnt_ff <= 32'h0;
                        st_ff <= ST_SAVE;
                     end
                     `ESS_CMD_LOAD: begin
                        busy_o <= 1'b1;
                        ld_one_ff <= cmd_arg_i != 16'h0000;
                        sect_ff <= cmd_arg_i[2:0];
                        idx_ff <= 4'h0;
                        st_ff <= ST_CHK;
                     end
                     default: cmd_err_o <= 1'b1;
                  endcase
               end
            end
            ST_SAVE: begin
               cnt_ff <= 32'h0;
               st_ff <= ST_SWAIT;
            end
            ST_SWAIT: begin
               // Write time per word; each word also cut off at SAVE_CYC
               cnt_ff <= cnt_ff + 32'h1;
               if (cnt_ff >= WR_CYC - 1 || cnt_ff >= SAVE_CYC - 1) begin
                  if (ld_one_ff || idx_ff == `ESS_IMG_WORDS - 1) begin
                     cmd_done_o <= 1'b1;
                     st_ff <= ST_IDLE;
                  end else begin
                     idx_ff <= idx_ff + 4'h1;
                     st_ff <= ST_SAVE;
                  end
               end
            end
            ST_CHK: st_ff <= ST_CHK2;
            ST_CHK2: begin
               // validity mark checked before copy
               // Only an exact mark loads; blank storage falls to error
               if (mem_rdata == `ESS_IMG_MARK) begin
                  idx_ff <= ld_one_ff ? {1'b0, sect_ff} : 4'h1;
                  st_ff <= ST_LOAD;
               end else begin
                  cmd_err_o <= 1'b1;
                  st_ff <= ST_IDLE;
               end
            end
            ST_LOAD: st_ff <= ST_LOAD2;
            ST_LOAD2: begin
               case (idx_ff[2:0])
                  3'h1: switches_o <= mem_rdata[`ESS_SW_W-1:0];
                  3'h2: begin
                     p_tbaud_ff <= mem_rdata[11:8];
                     p_tstop_ff <= mem_rdata[7:6];
                     p_tpar_ff <= mem_rdata[5:4];
                     p_hstop_ff <= mem_rdata[3:2];
                     p_hpar_ff <= mem_rdata[1:0];
                  end
                  3'h3: begin
                     host_baud_o <= mem_rdata[12:9];
                     user_o <= mem_rdata[8];
                     lines_o <= mem_rdata[7:0];
                  end
                  3'h4: begin
                     xon_o <= mem_rdata[13:7];
                     xoff_o <= mem_rdata[6:0];
                  end
                  3'h5: term_esc_o <= mem_rdata[13:0];
                  3'h6: host_esc_o <= mem_rdata[13:0];
                  3'h7: reset_char_o <= mem_rdata[6:0];
                  default: idx_ff <= idx_ff;
               endcase
               if (ld_one_ff || idx_ff == `ESS_IMG_WORDS - 1) begin
                  cmd_done_o <= 1'b1;
                  st_ff <= ST_IDLE;
               end else begin
                  idx_ff <= idx_ff + 4'h1;
                  st_ff <= ST_LOAD;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // ******************************************
   // Emulation controls
   // ******************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         break_o <= 1'b0;
         fsi_o <= 1'b0;
         ready_o <= 1'b0;
         clk_sel_int_o <= 1'b1;
         term_tx_en_o <= 1'b1;
         host_tx_en_o <= 1'b0;
      end else begin
         break_o <= switches_o[`ESS_SW_BKX] ? exec_match_i : fetch_match_i;
         fsi_o <= switches_o[`ESS_SW_FSX] ? fsi_exec_i : fsi_fetch_i;
         ready_o <= (switches_o[`ESS_SW_RDY] && overlay_i) ? 1'b1 :
            tgt_ready_i;
         clk_sel_int_o <= switches_o[`ESS_SW_CLK];
         term_tx_en_o <= !host_ctl_i || switches_o[`ESS_SW_CPY];
         host_tx_en_o <= host_ctl_i || switches_o[`ESS_SW_CPY];
      end
   end
endmodule // ess_top
`default_nettype wire

/* tb/ess_chk_assertions.sv */
// Purpose: port checks of the switch settings bank
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to ess_top; outputs registered one cycle
`timescale 1ns/1ns
`default_nettype none
`include "ess_defs.vh"
module ess_chk #(parameter NCS = 5) (
   // Clock, reset, command
   input wire logic clk_i, rst_n_i, cmd_vld_i, busy_o, cmd_done_o,
   input wire logic cmd_err_o,
   input wire logic [2:0] cmd_i,
   // Serial
   input wire logic term_rx_vld_i, host_rx_vld_i, self_reset_o,
   input wire logic [6:0] term_rx_i, host_rx_i, reset_char_o,
   // Emulation
   input wire logic run_i, exec_match_i, fetch_match_i, fsi_exec_i,
   input wire logic fsi_fetch_i, overlay_i, tgt_ready_i, break_o, fsi_o,
   input wire logic ready_o, clk_sel_int_o, dma_en_o, irq_step_en_o,
   input wire logic [2:0] timer_en_o,
   input wire logic [NCS-1:0] cs_rd_o,
   input wire logic [`ESS_SW_W-1:0] switches_o
);
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_break_exec: assert property (break_o ==
      $past(switches_o[0] ? exec_match_i : fetch_match_i)) else $error("break source");
   chk_clk_select: assert property (clk_sel_int_o ==
      $past(switches_o[1])) else $error("clock select");
   chk_fsi_exec: assert property (fsi_o ==
      $past(switches_o[3] ? fsi_exec_i : fsi_fetch_i)) else $error("fsi source");
   chk_ready_src: assert property (ready_o ==
      $past(switches_o[4] && overlay_i || tgt_ready_i)) else $error("ready");
   chk_dma_pause: assert property (dma_en_o ==
      $past(run_i || switches_o[5])) else $error("dma enable");
   chk_timer_pause: assert property (timer_en_o ==
      $past({3{run_i}} | switches_o[8:6])) else $error("timer enable");
   chk_step_irq: assert property (irq_step_en_o ==
      $past(switches_o[9])) else $error("step enable");
   chk_cs_group: assert property ($fell(run_i) && switches_o[10]
      |-> ##[1:2] &cs_rd_o[NCS-1:1]) else $error("cs readback");
   // every switch or set command answered
   chk_cmd_answer: assert property (cmd_vld_i && !busy_o &&
      cmd_i inside {3'h1, 3'h2, 3'h3} |=> cmd_done_o != cmd_err_o)
      else $error("no answer");
   chk_reset_char: assert property ((term_rx_vld_i &&
      term_rx_i == reset_char_o || host_rx_vld_i && host_rx_i == reset_char_o)
      |=> self_reset_o) else $error("no self reset");
   chk_save_busy: assert property (cmd_vld_i && !busy_o &&
      cmd_i == 3'h5 |=> busy_o [*3]) else $error("save busy");
endmodule // ess_chk
bind ess_top ess_chk #(.NCS(NCS)) ess_chk_inst (.clk_i, .rst_n_i, .cmd_vld_i,
   .busy_o, .cmd_done_o, .cmd_err_o, .cmd_i, .term_rx_vld_i, .host_rx_vld_i,
   .self_reset_o, .term_rx_i, .host_rx_i, .reset_char_o, .run_i,
   .exec_match_i, .fetch_match_i, .fsi_exec_i, .fsi_fetch_i, .overlay_i,
   .tgt_ready_i, .break_o, .fsi_o, .ready_o, .clk_sel_int_o, .dma_en_o,
   .irq_step_en_o, .timer_en_o, .cs_rd_o, .switches_o);
`default_nettype wire

/* tb/ess_link.sv */
// Purpose: terminal and host ports sending characters
// Assumes: one-cycle strobe per character
// Notes: idle data shows the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module ess_link (
   input wire logic clk_i,
   output logic term_rx_vld_o, host_rx_vld_o,
   output logic [6:0] term_rx_o, host_rx_o
);
   initial {term_rx_vld_o, host_rx_vld_o, term_rx_o, host_rx_o} = 16'h2a55;
   task send(input logic host, input logic [6:0] ch);
      begin
         @(posedge clk_i); #1;
         if (host) {host_rx_vld_o, host_rx_o} = {1'b1, ch};
         else {term_rx_vld_o, term_rx_o} = {1'b1, ch};
         @(posedge clk_i); #1;
         {term_rx_vld_o, host_rx_vld_o} = 2'h0;
         term_rx_o = ~term_rx_o;
         host_rx_o = ~host_rx_o;
      end
   endtask
endmodule // ess_link
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench of the switch settings bank
// Assumes: WR_CYC shortened to 4 so saves stay short
// Notes: emulation inputs random from a fixed-seed shift register
`timescale 1ns/1ns
`default_nettype none
`include "ess_defs.vh"
module tb;
   logic clk_i, rst_n_i, cmd_vld_i, host_ctl_i, run_i, go, e;
   logic exec_match_i, fetch_match_i, fsi_exec_i, fsi_fetch_i;
   logic overlay_i, tgt_ready_i;
   logic [2:0] cmd_i;
   logic [15:0] cmd_arg_i;
   logic [7:0] cmd_par_i, cmd_val_i, cmd_val2_i, p, v;
   logic [4:0] cs_wr_i;
   logic [31:0] rnd, ms;
   logic [3:0] prev;
   logic [1:0] exp_q[$];
   int err_total, check_count, i;
   wire term_rx_vld_i, host_rx_vld_i, cmd_done_o, cmd_err_o, busy_o;
   wire term_tx_en_o, host_tx_en_o, self_reset_o;
   wire [6:0] term_rx_i, host_rx_i, reset_char_o, xon_o, xoff_o;
   wire [10:0] switches_o;
   wire [3:0] term_baud_o, host_baud_o;
   wire [1:0] term_stop_o, term_par_o, host_stop_o, host_par_o;
   wire [13:0] term_esc_o, host_esc_o;
   wire [7:0] lines_o;
   ess_top #(.WR_CYC(4)) ess_top_inst (.clk_i, .rst_n_i, .cmd_vld_i,
      .cmd_i, .cmd_arg_i, .cmd_par_i, .cmd_val_i, .cmd_val2_i, .cmd_done_o,
      .cmd_err_o, .busy_o, .term_rx_vld_i, .term_rx_i, .host_rx_vld_i,
      .host_rx_i, .host_ctl_i, .self_reset_o, .term_tx_en_o, .host_tx_en_o,
      .run_i, .cs_wr_i, .exec_match_i, .fetch_match_i, .fsi_exec_i,
      .fsi_fetch_i, .overlay_i, .tgt_ready_i, .break_o(), .fsi_o(),
      .ready_o(), .clk_sel_int_o(), .switches_o, .dma_en_o(),
      .timer_en_o(), .cs_rd_o(), .irq_step_en_o(), .term_baud_o,
      .term_stop_o, .term_par_o, .host_baud_o, .host_stop_o, .host_par_o,
      .reset_char_o, .xon_o, .xoff_o, .term_esc_o, .host_esc_o, .lines_o,
      .user_o());
   ess_link ess_link_inst (.clk_i, .term_rx_vld_o(term_rx_vld_i),
      .host_rx_vld_o(host_rx_vld_i), .term_rx_o(term_rx_i),
      .host_rx_o(host_rx_i));
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task cmp_ans(input [1:0] x, input [1:0] g);
      begin
         check_count++;
         if (g !== x) begin
            err_total++;
            $display("Error t=%0t exp=%h got=%h", $time, x, g);
         end
      end
   endtask
   task cmp_val(input [15:0] x, input [15:0] g);
      begin
         check_count++;
         if (g !== x) begin
            err_total++;
            $display("Error t=%0t exp=%h got=%h", $time, x, g);
         end
      end
   endtask
   // Command strobe, answer noted for the monitor, then wait out busy
   task cmd(input [2:0] c, input [15:0] a, input [7:0] pr, v1, v2,
         input logic er);
      int n;
      begin
         @(posedge clk_i); #1;
         {cmd_vld_i, cmd_i, cmd_arg_i, cmd_par_i} = {1'b1, c, a, pr};
         {cmd_val_i, cmd_val2_i} = {v1, v2};
         exp_q.push_back({~er, er});
         @(posedge clk_i); #1;
         cmd_vld_i = 1'b0;
         n = 0;
         @(posedge clk_i); #1;
         while (busy_o !== 1'b0 && n < 2000) begin
            @(posedge clk_i); #1;
            n++;
         end
         @(posedge clk_i); #1;
      end
   endtask
   task test_done;
      begin
         if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   always @(posedge clk_i) if (cmd_done_o === 1'b1 || cmd_err_o === 1'b1)
      cmp_ans(exp_q.size() ? exp_q.pop_front() : 2'h0,
         {cmd_done_o, cmd_err_o});
   always @(posedge clk_i) if (go) begin
      #1;
      rnd = lfsr(rnd);
      {exec_match_i, fetch_match_i, fsi_exec_i, fsi_fetch_i} = rnd[3:0];
      {overlay_i, tgt_ready_i, run_i} = rnd[6:4];
      cs_wr_i = rnd[11:7] & {5{rnd[12]}};
   end
   initial forever #5 clk_i = ~clk_i;
   initial begin
      #500000;
      err_total++;
      test_done;
   end
   initial begin
      {clk_i, rst_n_i, cmd_vld_i, cmd_i, cmd_arg_i, cmd_par_i} = 0;
      {cmd_val_i, cmd_val2_i, cs_wr_i, host_ctl_i, run_i, go} = 0;
      {exec_match_i, fetch_match_i, fsi_exec_i, fsi_fetch_i} = 0;
      {overlay_i, tgt_ready_i} = 0;
      {err_total, check_count, rnd, ms} = {32'h0, 32'h0, 32'hc0c2, 32'hc0c2};
      repeat (3) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      cmp_val(`ESS_SW_RST, {5'h0, switches_o});
      go = 1'b1;
      for (i = 0; i < 8; i++) begin
         ms = lfsr(ms);
         cmd(`ESS_CMD_OFF, 16'hffff, 0, 0, 0, 0);
         cmd(`ESS_CMD_ON, {5'h0, ms[10:0]}, 0, 0, 0, 0);
         cmp_val({5'h0, ms[10:0]}, {5'h0, switches_o});
         host_ctl_i = ms[16];
         repeat (2) @(posedge clk_i); #1;
         cmp_val({ms[16] | ms[2], !ms[16] | ms[2]},
            {host_tx_en_o, term_tx_en_o});
      end
      prev = `ESS_BAUD_RST;
      for (i = 0; i < 16; i++) begin
         cmd(`ESS_CMD_SET, 0, `ESS_P_T_BAUD, i, 0, 0);
         cmp_val(prev, term_baud_o);
         ess_link_inst.send(i[0], `ESS_RSTCH_RST);
         @(posedge clk_i); #1;
         cmp_val(i, term_baud_o);
         prev = i;
      end
      for (i = 0; i < 10; i++) begin
         p = i < 5 ? (i < 2 ? `ESS_P_T_STOP : `ESS_P_T_PAR)
            : (i < 7 ? `ESS_P_C_STOP : `ESS_P_C_PAR);
         v = i % 5 < 2 ? i % 5 + 1 : i % 5 - 2;
         cmd(`ESS_CMD_SET, 0, p, v, 0, 0);
         ess_link_inst.send(1'b1, `ESS_RSTCH_RST);
         @(posedge clk_i); #1;
         cmp_val(v, i < 2 ? term_stop_o : i < 5 ? term_par_o
            : i < 7 ? host_stop_o : host_par_o);
      end
      cmd(`ESS_CMD_SET, 0, `ESS_P_C_BAUD, 5, 0, 0);
      cmp_val(5, host_baud_o);
      cmd(`ESS_CMD_SET, 0, `ESS_P_T_STOP, 3, 0, 1);
      cmd(`ESS_CMD_SET, 0, `ESS_P_T_PAR, 3, 0, 1);
      cmd(`ESS_CMD_SET, 0, `ESS_P_LINES, 4, 0, 1);
      cmd(`ESS_CMD_SET, 0, 8'h63, 1, 0, 1);
      cmd(3'h7, 0, 0, 0, 0, 1);
      ess_link_inst.send(1'b0, `ESS_RSTCH_RST);
      @(posedge clk_i); #1;
      cmp_val(4'ha, {term_stop_o, term_par_o});
      cmd(`ESS_CMD_SET, 0, `ESS_P_LINES, 5, 0, 0);
      cmd(`ESS_CMD_SET, 0, `ESS_P_XON, 8'h21, 8'h22, 0);
      cmd(`ESS_CMD_SET, 0, `ESS_P_T_ESC, 8'h31, 8'h32, 0);
      cmd(`ESS_CMD_SET, 0, `ESS_P_C_ESC, 8'h41, 8'h42, 0);
      cmp_val(5, lines_o);
      cmp_val({7'h21, 7'h22}, {xon_o, xoff_o});
      cmp_val({7'h31, 7'h32}, term_esc_o);
      cmp_val({7'h41, 7'h42}, host_esc_o);
      cmd(`ESS_CMD_LOAD, 0, 0, 0, 0, 1);
      cmd(`ESS_CMD_SAVE, 0, 0, 0, 0, 0);
      cmd(`ESS_CMD_SET, 0, `ESS_P_XON, 8'h11, 8'h13, 0);
      cmd(`ESS_CMD_LOAD, 0, 0, 0, 0, 0);
      cmd(`ESS_CMD_LOAD, 1, 0, 0, 0, 0);
      cmp_val({7'h21, 7'h22}, {xon_o, xoff_o});
      cmd(`ESS_CMD_SET, 0, `ESS_P_RSTCH2, 8'h05, 0, 0);
      cmp_val(5, reset_char_o);
      ess_link_inst.send(1'b1, 7'h05);
      cmp_val(1, self_reset_o);
      @(posedge clk_i); #1;
      cmp_val(0, self_reset_o);
      repeat (4) @(posedge clk_i);
      test_done;
   end
endmodule // tb
`default_nettype wire
